// ===== logic/mfs_defines.svh
`ifndef MFS_DEFINES_SVH
`define MFS_DEFINES_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define MFS_OFS_CTRL 8'h00
`define MFS_OFS_STATUS 8'h04
`define MFS_OFS_IRQ_STAT 8'h08
`define MFS_OFS_IRQ_MASK 8'h0C
`define MFS_OFS_CFG 8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define MFS_CTRL_AUTO_BIT 0
`define MFS_ST_LATCH_BIT 0
`define MFS_ST_PWR_BIT 1
`define MFS_ST_CODE_LSB 8
`define MFS_IRQ_TRIP_BIT 0
`define MFS_IRQ_CLEAR_BIT 1
`define MFS_CFG_THR_LSB 0
`define MFS_CFG_TIME_LSB 16

// ----------------------------------------
// reset values
// ----------------------------------------
`define MFS_RST_CTRL 1'h0
`define MFS_RST_MASK 2'h0
`define MFS_RST_THR_PCT 8'h14
`define MFS_RST_TRIP_MS 16'h03E8

// ----------------------------------------
// fault codes
// ----------------------------------------
`define MFS_CODE_NONE 8'h00
`define MFS_CODE_PHASE_LOSS 8'h03
`define MFS_CODE_OVERTEMP 8'h04

// ----------------------------------------
// timing
// ----------------------------------------
`define MFS_CLK_PERIOD_NS 100
`define MFS_MS_NS 1000000
`define MFS_MS_CYCLES (`MFS_MS_NS / `MFS_CLK_PERIOD_NS)
`define MFS_AUTO_DELAY_MS 16'h03E8
`define MFS_FLASH_PERIOD_MS 10'h3E8
`define MFS_FLASH_ON_MS 10'h0FA

`endif

// ===== logic/mfs_pkg.sv
package mfs_pkg;

	// supervisor states
	typedef enum logic [0:0] {
		MFS_RUN = 1'b0,
		MFS_TRIP = 1'b1
	} mfs_state_e;

	// measured conditions from the analog front ends and sequencer
	typedef struct packed {
		logic starting;
		logic full_voltage;
		logic [2:0] supply_present;
		logic motor_connected;
		logic [7:0] current_pct;
		logic heatsink_hot;
		logic temp_sensor_ok;
	} mfs_sense_s;

	// operator and remote reset sources
	typedef struct packed {
		logic reset_key;
		logic remote_reset_input_a;
		logic remote_reset_input_b;
	} mfs_reset_src_s;

endpackage

// ===== logic/mfs_supervisor.sv
`timescale 1ns/1ps
`include "mfs_defines.svh"
// Contract
// - fault blocks power stage while latched
// - latched fault flashes its identifying led
// - no resume without a reset event
// - power-on reset clears latched fault
// - front-panel key press clears fault
// - auto reset only when switch enabled
// - either remote input clears fault
// - start: missing supply or motor trips
// - full voltage undercurrent trips after time
// - defaults one second, twenty percent
// - overtemp single flash, ready stays lit
// - missing temperature sensor trips overtemp
module mfs_supervisor #(
	parameter int MS_CYCLES = `MFS_MS_CYCLES
) (
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// sensing and reset sources
	input wire mfs_pkg::mfs_sense_s sense_i,
	input wire mfs_pkg::mfs_reset_src_s rst_src_i,
	// power stage, leds, interrupt
	output logic power_enable_o,
	output logic led_phase_loss_o,
	output logic led_fault_o,
	output logic led_ready_o,
	output logic irq_o
);

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	mfs_pkg::mfs_state_e state;
	mfs_pkg::mfs_state_e next_state;
	logic [7:0] code;
	logic auto_en;
	logic [7:0] thr_pct;
	logic [15:0] trip_ms;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic [31:0] ms_cnt;
	logic ms_tick;
	logic [15:0] pl_ms;
	logic [15:0] auto_ms;
	logic [9:0] flash_ms;
	logic flash_on;
	logic [2:0] src_prev;
	logic [2:0] src_rise;
	logic key_rise;
	logic rem_rise;
	logic auto_fire;
	logic clear_evt;
	logic pl_cond;
	logic ot_cond;
	logic pl_trip;
	logic wb_req;
	logic wr_ctrl;
	logic wr_irq;
	logic wr_mask;
	logic wr_cfg;
	logic [31:0] cfg_word;
	logic [31:0] cfg_new;

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_ctrl = wb_req && wb_we_i && (wb_adr_i == `MFS_OFS_CTRL);
	assign wr_irq = wb_req && wb_we_i && (wb_adr_i == `MFS_OFS_IRQ_STAT);
	assign wr_mask = wb_req && wb_we_i && (wb_adr_i == `MFS_OFS_IRQ_MASK);
	assign wr_cfg = wb_req && wb_we_i && (wb_adr_i == `MFS_OFS_CFG);
	assign cfg_word = (32'(thr_pct) << `MFS_CFG_THR_LSB) | (32'(trip_ms) << `MFS_CFG_TIME_LSB);
	assign cfg_new = merge_sel(cfg_word, wb_dat_i, wb_sel_i);

	// ----------------------------------------
	// millisecond tick and flash timebase
	// ----------------------------------------
	assign ms_tick = (ms_cnt == 32'(MS_CYCLES - 1));
	assign flash_on = (flash_ms < `MFS_FLASH_ON_MS);

	always_ff @(posedge clk_i) begin
		if (rst_i || ms_tick) begin
			ms_cnt <= 32'h0;
		end else begin
			ms_cnt <= ms_cnt + 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_ms <= 10'h0;
		end else if (ms_tick) begin
			flash_ms <= (flash_ms == `MFS_FLASH_PERIOD_MS - 10'h1) ? 10'h0 : flash_ms + 10'h1;
		end
	end

	// ----------------------------------------
	// reset sources
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_prev <= 3'h0;
		end else begin
			src_prev <= rst_src_i;
		end
	end

	assign src_rise = rst_src_i & ~src_prev;
	assign key_rise = src_rise[2];
	assign rem_rise = src_rise[1] || src_rise[0];
	assign auto_fire = auto_en && (state == mfs_pkg::MFS_TRIP) && (auto_ms >= `MFS_AUTO_DELAY_MS);
	assign clear_evt = key_rise || rem_rise || auto_fire;

	always_ff @(posedge clk_i) begin
		if (rst_i || state != mfs_pkg::MFS_TRIP) begin
			auto_ms <= 16'h0;
		end else if (ms_tick && auto_ms != 16'hFFFF) begin
			auto_ms <= auto_ms + 16'h1;
		end
	end

	// ----------------------------------------
	// fault detection
	// ----------------------------------------
	// missing phase or motor while starting, or undercurrent at full voltage
	assign pl_cond = (sense_i.starting && (!(&sense_i.supply_present) || !sense_i.motor_connected)) ||
		(sense_i.full_voltage && (sense_i.current_pct < thr_pct));
	assign ot_cond = sense_i.heatsink_hot || !sense_i.temp_sensor_ok;
	assign pl_trip = pl_cond && (pl_ms >= trip_ms);

	always_ff @(posedge clk_i) begin
		if (rst_i || !pl_cond || state == mfs_pkg::MFS_TRIP) begin
			pl_ms <= 16'h0;
		end else if (ms_tick && pl_ms != 16'hFFFF) begin
			pl_ms <= pl_ms + 16'h1;
		end
	end

	// ----------------------------------------
	// fault latch
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			mfs_pkg::MFS_RUN: begin
				if (ot_cond || pl_trip) begin
					next_state = mfs_pkg::MFS_TRIP;
				end
			end
			mfs_pkg::MFS_TRIP: begin
				// leave only on a reset event
				if (clear_evt) begin
					next_state = mfs_pkg::MFS_RUN;
				end
			end
			default: begin
				next_state = mfs_pkg::MFS_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= mfs_pkg::MFS_RUN;
		end else begin
			state <= next_state;
		end
	end

	// code captured on first trip only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code <= `MFS_CODE_NONE;
		end else if (state == mfs_pkg::MFS_RUN && ot_cond) begin
			code <= `MFS_CODE_OVERTEMP;
		end else if (state == mfs_pkg::MFS_RUN && pl_trip) begin
			code <= `MFS_CODE_PHASE_LOSS;
		end else if (state == mfs_pkg::MFS_TRIP && clear_evt) begin
			code <= `MFS_CODE_NONE;
		end
	end

	// ----------------------------------------
	// power stage and leds
	// ----------------------------------------
	// power stage blocked on trip
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			power_enable_o <= 1'b0;
		end else begin
			power_enable_o <= (next_state == mfs_pkg::MFS_RUN);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			led_phase_loss_o <= 1'b0;
			led_fault_o <= 1'b0;
			led_ready_o <= 1'b0;
		end else begin
			led_phase_loss_o <= (state == mfs_pkg::MFS_TRIP) && (code == `MFS_CODE_PHASE_LOSS) && flash_on;
			led_fault_o <= (state == mfs_pkg::MFS_TRIP) && (code == `MFS_CODE_OVERTEMP) && flash_on;
			led_ready_o <= 1'b1;
		end
	end

	// ----------------------------------------
	// registers and interrupt
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			auto_en <= `MFS_RST_CTRL;
			irq_mask <= `MFS_RST_MASK;
			thr_pct <= `MFS_RST_THR_PCT;
			trip_ms <= `MFS_RST_TRIP_MS;
		end else begin
			if (wr_ctrl && wb_sel_i[0]) begin
				auto_en <= wb_dat_i[`MFS_CTRL_AUTO_BIT];
			end
			if (wr_mask && wb_sel_i[0]) begin
				irq_mask <= wb_dat_i[1:0];
			end
			if (wr_cfg) begin
				thr_pct <= cfg_new[`MFS_CFG_THR_LSB +: 8];
				trip_ms <= cfg_new[`MFS_CFG_TIME_LSB +: 16];
			end
		end
	end

	// write one to clear; a same-cycle event wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= 2'h0;
		end else begin
			irq_stat[`MFS_IRQ_TRIP_BIT] <= (state == mfs_pkg::MFS_RUN && next_state == mfs_pkg::MFS_TRIP) ||
				(irq_stat[`MFS_IRQ_TRIP_BIT] && !(wr_irq && wb_sel_i[0] && wb_dat_i[`MFS_IRQ_TRIP_BIT]));
			irq_stat[`MFS_IRQ_CLEAR_BIT] <= (state == mfs_pkg::MFS_TRIP && clear_evt) ||
				(irq_stat[`MFS_IRQ_CLEAR_BIT] && !(wr_irq && wb_sel_i[0] && wb_dat_i[`MFS_IRQ_CLEAR_BIT]));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_stat & irq_mask);
		end
	end

	// ----------------------------------------
	// wishbone answer
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					`MFS_OFS_CTRL: begin
						wb_dat_o <= 32'(auto_en) << `MFS_CTRL_AUTO_BIT;
					end
					`MFS_OFS_STATUS: begin
						wb_dat_o <= (32'(state == mfs_pkg::MFS_TRIP) << `MFS_ST_LATCH_BIT) |
							(32'(power_enable_o) << `MFS_ST_PWR_BIT) | (32'(code) << `MFS_ST_CODE_LSB);
					end
					`MFS_OFS_IRQ_STAT: begin
						wb_dat_o <= 32'(irq_stat);
					end
					`MFS_OFS_IRQ_MASK: begin
						wb_dat_o <= 32'(irq_mask);
					end
					`MFS_OFS_CFG: begin
						wb_dat_o <= cfg_word;
					end
					default: begin
						wb_dat_o <= 32'h0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_tripped;
		state == mfs_pkg::MFS_TRIP;
	endsequence
	sequence s_ot_shown;
		state == mfs_pkg::MFS_TRIP && code == `MFS_CODE_OVERTEMP;
	endsequence
	property p_blocked;
		s_tripped |-> !power_enable_o;
	endproperty
	a_blocked: assert property (p_blocked) else $error("power enabled while tripped");
	property p_flash;
		led_phase_loss_o |-> $past(state == mfs_pkg::MFS_TRIP && code == `MFS_CODE_PHASE_LOSS);
	endproperty
	a_flash: assert property (p_flash) else $error("phase loss led without fault");
	property p_hold;
		s_tripped ##0 !clear_evt |=> s_tripped ##0 $stable(code);
	endproperty
	a_hold: assert property (p_hold) else $error("latch left without reset");
	property p_key;
		s_tripped ##0 key_rise |=> state == mfs_pkg::MFS_RUN && power_enable_o;
	endproperty
	a_key: assert property (p_key) else $error("key did not clear fault");
	property p_auto;
		s_tripped ##0 (!auto_en && !key_rise && !rem_rise) |=> s_tripped;
	endproperty
	a_auto: assert property (p_auto) else $error("auto reset while disabled");
	property p_remote;
		s_tripped ##0 rem_rise |=> state == mfs_pkg::MFS_RUN;
	endproperty
	a_remote: assert property (p_remote) else $error("remote input did not clear");
	property p_pl_trip;
		state == mfs_pkg::MFS_RUN && pl_trip && !ot_cond |=> s_tripped ##0 code == `MFS_CODE_PHASE_LOSS;
	endproperty
	a_pl_trip: assert property (p_pl_trip) else $error("phase loss not latched");
	property p_ot_trip;
		state == mfs_pkg::MFS_RUN && ot_cond |=> s_ot_shown ##0 !power_enable_o;
	endproperty
	a_ot_trip: assert property (p_ot_trip) else $error("overtemp not latched");
	property p_ready;
		s_ot_shown |=> led_ready_o && !led_phase_loss_o;
	endproperty
	a_ready: assert property (p_ready) else $error("ready led off in overtemp");

endmodule

// ===== sim/mfs_plant_model.sv
`timescale 1ns/1ps
module mfs_plant_model (
	// system
	input wire logic clk_i,
	// plant side
	output mfs_pkg::mfs_sense_s sense_o,
	output mfs_pkg::mfs_reset_src_s rst_src_o
);
	logic hot = 1'b0;
	logic sensor_ok = 1'b1;
	logic [2:0] phases = 3'h7;
	logic motor_on = 1'b1;
	logic [1:0] stage = 2'h0;
	logic [7:0] load_pct = 8'h64;
	logic [2:0] pulses = 3'h0;
	logic [7:0] cur;
	// no current without all phases and the motor
	assign cur = (stage == 2'h2 && motor_on && &phases) ? load_pct : 8'h00;
	assign sense_o = {stage == 2'h1, stage == 2'h2, phases, motor_on, cur, hot, sensor_ok};
	assign rst_src_o = pulses;
	// one-cycle pulse: bit 2 key, bit 1 remote a, bit 0 remote b
	task automatic pulse(input int idx);
		@(posedge clk_i);
		pulses[idx] <= 1'b1;
		@(posedge clk_i);
		pulses <= 3'h0;
	endtask
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`include "mfs_defines.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic power_enable_o;
	logic led_phase_loss_o;
	logic led_fault_o;
	logic led_ready_o;
	logic irq_o;
	mfs_pkg::mfs_sense_s sense_i;
	mfs_pkg::mfs_reset_src_s rst_src_i;
	int fails = 0;
	int checked = 0;

	mfs_supervisor #(.MS_CYCLES(10)) i_mfs_supervisor (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sense_i(sense_i), .rst_src_i(rst_src_i),
		.power_enable_o(power_enable_o), .led_phase_loss_o(led_phase_loss_o), .led_fault_o(led_fault_o),
		.led_ready_o(led_ready_o), .irq_o(irq_o));
	mfs_plant_model i_mfs_plant_model (.clk_i(clk_i), .sense_o(sense_i), .rst_src_o(rst_src_i));

	initial begin
		forever #50 clk_i = ~clk_i;
	end

	task automatic stop_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// one classic wishbone cycle, answer taken at the ack edge
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) begin
			@(posedge clk_i);
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		`CHK(nm, e, q)
	endtask

	task automatic wait_pwr(input logic v, input int lim);
		int n;
		n = 0;
		while (power_enable_o !== v && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		`CHK("power_enable", v, power_enable_o)
	endtask

	// the led flashes, so wait up to one flash period for its on phase
	task automatic wait_phase_led(input int lim);
		int n;
		n = 0;
		while (led_phase_loss_o !== 1'b1 && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		`CHK("led_phase", 1'b1, led_phase_loss_o)
	endtask

	initial begin
		#6000000;
		$display("ERROR watchdog exp done got timeout");
		fails++;
		stop_test();
	end

	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		`CHK("led_ready", 1'b1, led_ready_o)
		rd(`MFS_OFS_STATUS, 32'h2, "status");
		rd(`MFS_OFS_CFG, 32'h03E80014, "cfg");
		rd(`MFS_OFS_CTRL, 32'h0, "ctrl");
		rd(8'h1C, 32'h0, "unmapped");
		wr(`MFS_OFS_IRQ_MASK, 32'h3);
		$display("test registers done");
		// ----------------------------------------
		// overtemp trip, later fault ignored
		// ----------------------------------------
		@(posedge clk_i);
		i_mfs_plant_model.hot <= 1'b1;
		wait_pwr(1'b0, 5);
		i_mfs_plant_model.stage <= 2'h1;
		i_mfs_plant_model.motor_on <= 1'b0;
		repeat (40) @(posedge clk_i);
		i_mfs_plant_model.hot <= 1'b0;
		i_mfs_plant_model.stage <= 2'h0;
		i_mfs_plant_model.motor_on <= 1'b1;
		rd(`MFS_OFS_STATUS, 32'h0401, "status");
		`CHK("led_fault", 1'b1, led_fault_o)
		`CHK("led_phase", 1'b0, led_phase_loss_o)
		`CHK("led_ready", 1'b1, led_ready_o)
		`CHK("irq", 1'b1, irq_o)
		repeat (4000) @(posedge clk_i);
		`CHK("led_fault", 1'b0, led_fault_o)
		`CHK("power_enable", 1'b0, power_enable_o)
		rd(`MFS_OFS_IRQ_STAT, 32'h1, "irq_stat");
		i_mfs_plant_model.pulse(2);
		wait_pwr(1'b1, 5);
		rd(`MFS_OFS_IRQ_STAT, 32'h3, "irq_stat");
		wr(`MFS_OFS_IRQ_STAT, 32'h3);
		rd(`MFS_OFS_IRQ_STAT, 32'h0, "irq_stat");
		`CHK("irq", 1'b0, irq_o)
		$display("test overtemp done");
		// ----------------------------------------
		// phase loss at start and undercurrent
		// ----------------------------------------
		wr(`MFS_OFS_CFG, 32'h00020014);
		i_mfs_plant_model.stage <= 2'h1;
		i_mfs_plant_model.motor_on <= 1'b0;
		repeat (8) @(posedge clk_i);
		`CHK("power_enable", 1'b1, power_enable_o)
		wait_pwr(1'b0, 40);
		rd(`MFS_OFS_STATUS, 32'h0301, "status");
		wait_phase_led(10000);
		i_mfs_plant_model.motor_on <= 1'b1;
		i_mfs_plant_model.stage <= 2'h2;
		i_mfs_plant_model.load_pct <= 8'h14;
		i_mfs_plant_model.pulse(1);
		wait_pwr(1'b1, 5);
		repeat (60) @(posedge clk_i);
		`CHK("power_enable", 1'b1, power_enable_o)
		i_mfs_plant_model.load_pct <= 8'h13;
		wait_pwr(1'b0, 40);
		i_mfs_plant_model.load_pct <= 8'h64;
		i_mfs_plant_model.pulse(0);
		wait_pwr(1'b1, 5);
		$display("test phase loss done");
		// ----------------------------------------
		// sensor missing, auto clear, power-on
		// ----------------------------------------
		i_mfs_plant_model.sensor_ok <= 1'b0;
		wait_pwr(1'b0, 5);
		i_mfs_plant_model.sensor_ok <= 1'b1;
		rd(`MFS_OFS_STATUS, 32'h0401, "status");
		repeat (11000) @(posedge clk_i);
		`CHK("power_enable", 1'b0, power_enable_o)
		wr(`MFS_OFS_CTRL, 32'h1);
		wait_pwr(1'b1, 11000);
		wr(`MFS_OFS_CTRL, 32'h0);
		i_mfs_plant_model.hot <= 1'b1;
		wait_pwr(1'b0, 5);
		i_mfs_plant_model.hot <= 1'b0;
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		`CHK("power_enable", 1'b1, power_enable_o)
		rd(`MFS_OFS_STATUS, 32'h2, "status");
		$display("test reset sources done");
		stop_test();
	end
endmodule
